// ===== bsfc_pkg.sv
// package of constants and types for the buck supervisor fault control block
package bsfc_pkg;
    // timebase
    localparam int CLK_MHZ = 100;
    // default-load time after enable, ns
    localparam int LOAD_NS = 120000;
    localparam int LOAD_CYC = LOAD_NS * CLK_MHZ / 1000;
    // soft start times, ns
    localparam int SS_STD_NS = 300000;
    localparam int SS_SLOW_NS = 880000;
    localparam int SS_STD_CYC = SS_STD_NS * CLK_MHZ / 1000;
    localparam int SS_SLOW_CYC = SS_SLOW_NS * CLK_MHZ / 1000;
    // power-ok start-up delay, typical and max, ns
    localparam int PGD_NS = 125000;
    localparam int PGD_MAX_NS = 180000;
    localparam int PGD_CYC = PGD_NS * CLK_MHZ / 1000;
    // power-ok blanking, ns
    localparam int BLANK_NS = 40000;
    localparam int BLANK_CYC = BLANK_NS * CLK_MHZ / 1000;
    // overvoltage deglitch, ns (least time, round up)
    localparam int OVP_NS = 35000;
    localparam int OVP_CYC = (OVP_NS * CLK_MHZ + 999) / 1000;
    // hiccup pause, ns
    localparam longint HIC_NS = 64'd9600000;
    localparam int HIC_CYC = int'(HIC_NS * CLK_MHZ / 1000);
    // switching period at 2 MHz: 500 ns
    localparam int PER_NS = 500;
    localparam int PER_CYC = PER_NS * CLK_MHZ / 1000;
    // consecutive limited cycles that trigger protection
    localparam int OC_LIMIT = 32;
    // skip-mode duty ceiling, percent
    localparam int DUTY_MAX_PCT = 90;
    localparam int PCT_FULL = 100;
    // thermal thresholds, deg C
    localparam int TSD_ON = 150;
    localparam int TSD_HYS = 20;
    // feedback window in mV
    localparam int FB_PG_RISE = 480;
    localparam int FB_OV_SET = 550;
    localparam int FB_OV_CLR = 525;
    // uvlo in mV
    localparam int UV_RISE = 2150;
    localparam int UV_HYS = 120;

    typedef enum logic [5:0] {
        BSFC_OFF = 6'h01,
        BSFC_LOAD = 6'h02,
        BSFC_SOFT = 6'h04,
        BSFC_RUN = 6'h08,
        BSFC_HICCUP = 6'h10,
        BSFC_LATCH = 6'h20
    } bsfc_state_t;

    // analog measurements, already digitised
    typedef struct packed {
        logic [12:0] vin_mv;
        logic [12:0] vout_mv;
        logic [11:0] fb_mv;
        logic [8:0] temp_c;
    } bsfc_meas_t;

    // power stage drive
    typedef struct packed {
        logic hs_on;
        logic ls_on;
        logic discharge_on;
    } bsfc_gate_t;
endpackage : bsfc_pkg

// ===== bsfc_filter.sv
// persistence filter: output follows input after it holds steady for a count
`timescale 1ns/1ps
`default_nettype none
module bsfc_filter #(
    parameter int COUNT = 4000,
    parameter bit INIT = 1'b0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic din,
    output logic dout
);
    logic [$clog2(COUNT+1)-1:0] cnt_reg;
    logic [$clog2(COUNT+1)-1:0] cnt_next;
    logic dout_next;
    logic differ;
    // count while input disagrees with output, restart on agreement
    assign differ = (din != dout);
    assign cnt_next = (!differ || clear) ? '0 : cnt_reg + 1'b1;
    assign dout_next = clear ? INIT : ((differ && cnt_reg == COUNT[$bits(cnt_reg)-1:0] - 1'b1) ? din : dout);
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            dout <= INIT;
        end else begin
            cnt_reg <= cnt_next;
            dout <= dout_next;
        end
    end
endmodule : bsfc_filter
`default_nettype wire

// ===== bsfc_top.sv
// supervisor and protection control for a synchronous step-down converter
// Overview of operation
// - mode high keeps forced pulse-width switching at every load
// - mode low: pulse-width above half ripple, skip mode with fixed on-time below
// - pulse-width period 2 MHz, on-time is vout/vin times 500 ns
// - never enter skip mode while duty exceeds 90 percent
// - rising enable loads defaults for 120 us, then soft start ramps
// - power ok held low 125 us (max 180 us) after soft start
// - prebias start only on first enable, here for the first soft-start clock only; discharge stays armed until supply cycle
// - high-side limit turns high off, low on (low stays off in prebias start), until next cycle start
// - variant selects hiccup or latch-off on repeated limits
// - hiccup: 32 limited cycles pause high side 9.6 ms, then soft start
// - latch-off: 32 limited cycles hold both switches off until enable cycle
// - latch-off variant: feedback near 110 percent for 35 us latches off
// - input below undervoltage threshold inhibits switching
// - thermal shutdown above 150 C, resume after 20 C drop
// - enable low: switches off, discharge sink on switch node once a first soft start has run and outside uvlo
// - output near input: 100 percent mode, high on, low off
// - power ok released at nominal, low when off, uvlo or thermal
// - power ok window: release at 0.48 V, low at 0.55 V, release at 0.525 V
// - window changes reach power ok only after 40 us of persistence both ways; leaving run pulls it low at once
// - soft start 300 us standard, 880 us slow variant
// - uvlo releases at 2.15 V rising, 120 mV hysteresis
`timescale 1ns/1ps
`default_nettype none
module bsfc_top #(
    parameter bit LATCH_VARIANT = 1'b0,
    parameter bit SLOW_START = 1'b0,
    parameter int HICCUP_CYCLES = bsfc_pkg::HIC_CYC,
    parameter int SS_CYCLES = SLOW_START ? bsfc_pkg::SS_SLOW_CYC : bsfc_pkg::SS_STD_CYC,
    parameter int LOAD_CYCLES = bsfc_pkg::LOAD_CYC,
    parameter int PGD_CYCLES = bsfc_pkg::PGD_CYC,
    parameter int BLANK_CYCLES = bsfc_pkg::BLANK_CYC,
    parameter int OVP_CYCLES = bsfc_pkg::OVP_CYC,
    parameter int NEAR_MV = 100
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic mode_fpwm,
    input wire logic hs_over_limit,
    input wire logic light_load,
    input wire logic vout_prebiased,
    input wire bsfc_pkg::bsfc_meas_t meas,
    output bsfc_pkg::bsfc_gate_t gate,
    output logic light_load_skip_mode,
    output logic full_duty_mode,
    output logic soft_start_active,
    output logic [6:0] on_time_cycles,
    output logic power_ok_flag_o,
    output logic power_ok_flag_oe,
    output logic fault_latched
);
    // ------------------------------------------------------------
    // protection conditions
    // ------------------------------------------------------------
    bsfc_pkg::bsfc_state_t state_reg, state_next;
    logic uvlo_reg, uvlo_next;
    logic tsd_reg, tsd_next;
    logic inhibit;

    // uvlo with hysteresis
    assign uvlo_next = uvlo_reg ? (meas.vin_mv < 13'(bsfc_pkg::UV_RISE))
                                : (meas.vin_mv < 13'(bsfc_pkg::UV_RISE - bsfc_pkg::UV_HYS));
    // thermal shutdown with hysteresis
    assign tsd_next = tsd_reg ? (meas.temp_c > 9'(bsfc_pkg::TSD_ON - bsfc_pkg::TSD_HYS))
                              : (meas.temp_c > 9'(bsfc_pkg::TSD_ON));
    assign inhibit = uvlo_reg || tsd_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            uvlo_reg <= 1'b1;
            tsd_reg <= 1'b0;
        end else begin
            uvlo_reg <= uvlo_next;
            tsd_reg <= tsd_next;
        end
    end

    // ------------------------------------------------------------
    // switching period timebase and current limit counter
    // ------------------------------------------------------------
    logic [7:0] per_reg, per_next;
    logic cycle_start;
    logic limited_reg, limited_next;
    logic [5:0] oc_cnt_reg, oc_cnt_next;
    logic oc_trip;
    logic switching;
    logic [6:0] ton_calc;
    logic [6:0] ton_reg;
    logic ton_active;

    assign switching = (state_reg == bsfc_pkg::BSFC_SOFT) || (state_reg == bsfc_pkg::BSFC_RUN);
    assign cycle_start = (per_reg == 8'(bsfc_pkg::PER_CYC - 1));
    assign per_next = (!switching || cycle_start) ? 8'h00 : per_reg + 8'h01;
    // limit seen in this cycle, cleared at next cycle start
    assign limited_next = switching && ((limited_reg && !cycle_start) || hs_over_limit);
    // consecutive limited cycles; a clean cycle or shutdown clears
    assign oc_cnt_next = !switching ? 6'h00
                       : !cycle_start ? oc_cnt_reg
                       : (limited_reg || hs_over_limit) ? oc_cnt_reg + 6'h01 : 6'h00;
    assign oc_trip = (oc_cnt_reg == 6'(bsfc_pkg::OC_LIMIT));
    // on-time = vout/vin * 500 ns in clock cycles
    assign ton_calc = (meas.vin_mv == 13'h0000) ? 7'h00
        : 7'(({19'h00000, meas.vout_mv} * 32'(bsfc_pkg::PER_CYC)) / {19'h00000, meas.vin_mv});
    assign ton_active = (per_reg < {1'b0, ton_reg});

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            per_reg <= 8'h00;
            limited_reg <= 1'b0;
            oc_cnt_reg <= 6'h00;
            ton_reg <= 7'h00;
        end else begin
            per_reg <= per_next;
            limited_reg <= limited_next;
            oc_cnt_reg <= oc_cnt_next;
            ton_reg <= ton_calc;
        end
    end

    // ------------------------------------------------------------
    // sequencing state machine and timers
    // ------------------------------------------------------------
    logic [23:0] tmr_reg, tmr_next;
    logic ovp_seen;
    logic ovp_hold;
    logic first_done_reg, first_done_next;
    logic pgd_done_reg, pgd_done_next;
    logic [23:0] pgd_reg, pgd_next;

    // overvoltage: feedback at or above 110 percent for the deglitch time
    bsfc_filter #(.COUNT(OVP_CYCLES), .INIT(1'b0)) u_ovp (
        .clock(clock),
        .rst_b(rst_b),
        .clear(!switching),
        .din(meas.fb_mv >= 12'(bsfc_pkg::FB_OV_SET)),
        .dout(ovp_seen)
    );
    assign ovp_hold = LATCH_VARIANT && ovp_seen;

    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg + 24'h000001;
        // a latched fault survives thermal shutdown; only enable or supply cycling clears it
        if (!enable || uvlo_reg || (tsd_reg && state_reg != bsfc_pkg::BSFC_LATCH)) begin
            state_next = bsfc_pkg::BSFC_OFF;
            tmr_next = 24'h000000;
        end else begin
            case (state_reg)
                bsfc_pkg::BSFC_OFF: begin
                    tmr_next = 24'h000000;
                    state_next = bsfc_pkg::BSFC_LOAD; // restart once enabled and clear
                end
                bsfc_pkg::BSFC_LOAD: begin
                    if (tmr_reg == 24'(LOAD_CYCLES - 1)) begin
                        state_next = bsfc_pkg::BSFC_SOFT;
                        tmr_next = 24'h000000;
                    end
                end
                bsfc_pkg::BSFC_SOFT, bsfc_pkg::BSFC_RUN: begin
                    if (oc_trip || ovp_hold) begin
                        tmr_next = 24'h000000;
                        if (LATCH_VARIANT || ovp_hold) begin
                            state_next = bsfc_pkg::BSFC_LATCH;
                        end else begin
                            state_next = bsfc_pkg::BSFC_HICCUP;
                        end
                    end else if (state_reg == bsfc_pkg::BSFC_SOFT &&
                                 tmr_reg == 24'(SS_CYCLES - 1)) begin
                        state_next = bsfc_pkg::BSFC_RUN;
                    end
                end
                bsfc_pkg::BSFC_HICCUP: begin
                    if (tmr_reg == 24'(HICCUP_CYCLES - 1)) begin
                        state_next = bsfc_pkg::BSFC_SOFT;
                        tmr_next = 24'h000000;
                    end
                end
                bsfc_pkg::BSFC_LATCH: begin
                    tmr_next = 24'h000000;
                end
                default: begin
                    state_next = bsfc_pkg::BSFC_OFF;
                    tmr_next = 24'h000000;
                end
            endcase
        end
    end

    // prebias start allowed once per supply cycle; later enables discharge first
    assign first_done_next = first_done_reg || (state_reg == bsfc_pkg::BSFC_SOFT);
    // start-up power ok delay counted from soft start end
    assign pgd_next = (state_reg != bsfc_pkg::BSFC_RUN) ? 24'h000000
                    : (pgd_done_reg ? pgd_reg : pgd_reg + 24'h000001);
    assign pgd_done_next = (state_reg == bsfc_pkg::BSFC_RUN) &&
                           (pgd_done_reg || pgd_reg == 24'(PGD_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= bsfc_pkg::BSFC_OFF;
            tmr_reg <= 24'h000000;
            first_done_reg <= 1'b0;
            pgd_reg <= 24'h000000;
            pgd_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            first_done_reg <= first_done_next;
            pgd_reg <= pgd_next;
            pgd_done_reg <= pgd_done_next;
        end
    end

    // ------------------------------------------------------------
    // mode selection and gate drive
    // ------------------------------------------------------------
    logic near_full;
    logic duty_high;
    logic skip_next;
    bsfc_pkg::bsfc_gate_t gate_next;
    logic full_next;

    assign near_full = ({1'b0, meas.vout_mv} + 14'(NEAR_MV)) >= {1'b0, meas.vin_mv};
    assign duty_high = ({7'h00, meas.vout_mv} * 20'(bsfc_pkg::PCT_FULL)) >
                       ({7'h00, meas.vin_mv} * 20'(bsfc_pkg::DUTY_MAX_PCT));
    assign skip_next = switching && !mode_fpwm && light_load && !duty_high;
    assign full_next = (state_reg == bsfc_pkg::BSFC_RUN) && near_full && !limited_next;

    always_comb begin
        gate_next = '0;
        case (state_reg)
            bsfc_pkg::BSFC_SOFT, bsfc_pkg::BSFC_RUN: begin
                if (!first_done_reg && vout_prebiased) begin
                    gate_next.hs_on = ton_active && !limited_next; // no sinking into prebias
                end else if (full_next) begin
                    gate_next.hs_on = 1'b1;
                end else if (limited_next) begin
                    gate_next.ls_on = 1'b1;
                end else begin
                    gate_next.hs_on = ton_active;
                    gate_next.ls_on = !ton_active && !skip_next;
                end
            end
            bsfc_pkg::BSFC_HICCUP: begin
                gate_next.ls_on = 1'b0; // high side off, current decays in body diode
            end
            bsfc_pkg::BSFC_OFF: begin
                gate_next.discharge_on = !enable && first_done_reg && !uvlo_reg;
            end
            default: begin
                gate_next = '0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gate <= '0;
            light_load_skip_mode <= 1'b0;
            full_duty_mode <= 1'b0;
            soft_start_active <= 1'b0;
            on_time_cycles <= 7'h00;
            fault_latched <= 1'b0;
        end else begin
            gate <= gate_next;
            light_load_skip_mode <= skip_next;
            full_duty_mode <= full_next;
            soft_start_active <= (state_reg == bsfc_pkg::BSFC_SOFT);
            on_time_cycles <= ton_reg;
            fault_latched <= (state_reg == bsfc_pkg::BSFC_LATCH);
        end
    end

    // ------------------------------------------------------------
    // power ok window and blanking
    // ------------------------------------------------------------
    logic win_ov_reg, win_ov_next;
    logic good_raw;
    logic good_filt;

    // overvoltage side of the window with hysteresis
    assign win_ov_next = win_ov_reg ? (meas.fb_mv > 12'(bsfc_pkg::FB_OV_CLR))
                                    : (meas.fb_mv >= 12'(bsfc_pkg::FB_OV_SET));
    assign good_raw = (meas.fb_mv >= 12'(bsfc_pkg::FB_PG_RISE)) && !win_ov_reg
                    && !ovp_hold;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            win_ov_reg <= 1'b0;
        end else begin
            win_ov_reg <= win_ov_next;
        end
    end

    bsfc_filter #(.COUNT(BLANK_CYCLES), .INIT(1'b0)) u_blank (
        .clock(clock),
        .rst_b(rst_b),
        .clear(!pgd_done_reg),
        .din(good_raw),
        .dout(good_filt)
    );

    // open drain: drive low unless good, never drive high
    assign power_ok_flag_o = 1'b0;
    assign power_ok_flag_oe = !(good_filt && pgd_done_reg && state_reg == bsfc_pkg::BSFC_RUN);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fpwm_no_skip: assert property (@(posedge clock) disable iff (!rst_b)
        mode_fpwm |=> !light_load_skip_mode) else $error("skip mode under forced pwm");
    a_duty_no_skip: assert property (@(posedge clock) disable iff (!rst_b)
        duty_high |=> !light_load_skip_mode) else $error("skip mode at high duty");
    a_limit_hs_off: assert property (@(posedge clock) disable iff (!rst_b)
        (hs_over_limit && switching) |=> !gate.hs_on) else $error("high side on in limit");
    a_off_no_switch: assert property (@(posedge clock) disable iff (!rst_b)
        (!enable && $past(!enable)) |=> !gate.hs_on && !gate.ls_on) else $error("switching off");
    a_latch_held: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == bsfc_pkg::BSFC_LATCH && enable && !inhibit) |=>
        state_reg == bsfc_pkg::BSFC_LATCH) else $error("latch left");
    a_uvlo_inhibit: assert property (@(posedge clock) disable iff (!rst_b)
        uvlo_reg |=> state_reg == bsfc_pkg::BSFC_OFF) else $error("runs in uvlo");
    a_tsd_pg_low: assert property (@(posedge clock) disable iff (!rst_b)
        tsd_reg |=> ##1 power_ok_flag_oe) else $error("power ok in thermal");
    a_trip_leaves: assert property (@(posedge clock) disable iff (!rst_b)
        (oc_trip && switching && enable && !inhibit) |=> !switching) else $error("no trip");
    a_pg_after_soft: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(soft_start_active) |-> power_ok_flag_oe [*8]) else $error("pg early");
endmodule : bsfc_top
`default_nettype wire

// ===== bsfc_stage_model.sv
// power stage model: high-side current comparator of the converter
`timescale 1ns/1ps
`default_nettype none
module bsfc_stage_model (
    input wire logic overload,
    input wire bsfc_pkg::bsfc_gate_t gate,
    output logic hs_over_limit
);
    // comparator trips only while the high side conducts into an overload
    assign hs_over_limit = overload & gate.hs_on;
endmodule : bsfc_stage_model
`default_nettype wire

// ===== bsfc_top_tb.sv
// self-checking testbench for the buck supervisor with hiccup and latch-off variants
`timescale 1ns/1ps
`default_nettype none
module bsfc_top_tb;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int LD = 20;
    localparam int SS = 50;
    localparam int PD = 20;
    localparam int BL = 10;
    localparam int HC = 200;
    localparam int PER = bsfc_pkg::PER_CYC;
    logic clock;
    logic rst_b;
    logic enable;
    logic mode_fpwm;
    logic light_load;
    logic vout_prebiased;
    logic overload;
    logic limit_hic;
    logic limit_lat;
    bsfc_pkg::bsfc_meas_t meas;
    bsfc_pkg::bsfc_gate_t gate_hic;
    bsfc_pkg::bsfc_gate_t gate_lat;
    logic skip_hic;
    logic full_hic;
    logic ss_hic;
    logic [6:0] ont_hic;
    logic oe_hic;
    logic pgo_hic;
    logic oe_lat;
    logic fault_lat;
    int failures;
    int comparisons;
    int cycles = 0;
    // hiccup variant
    bsfc_top #(.LATCH_VARIANT(1'b0), .HICCUP_CYCLES(HC), .SS_CYCLES(SS), .LOAD_CYCLES(LD),
        .PGD_CYCLES(PD), .BLANK_CYCLES(BL), .OVP_CYCLES(5)) DUT (
        .clock(clock), .rst_b(rst_b), .enable(enable), .mode_fpwm(mode_fpwm),
        .hs_over_limit(limit_hic), .light_load(light_load), .vout_prebiased(vout_prebiased),
        .meas(meas), .gate(gate_hic), .light_load_skip_mode(skip_hic), .full_duty_mode(full_hic),
        .soft_start_active(ss_hic), .on_time_cycles(ont_hic), .power_ok_flag_o(pgo_hic),
        .power_ok_flag_oe(oe_hic), .fault_latched());
    // latch-off variant sharing every input except its own comparator
    bsfc_top #(.LATCH_VARIANT(1'b1), .HICCUP_CYCLES(HC), .SS_CYCLES(SS), .LOAD_CYCLES(LD),
        .PGD_CYCLES(PD), .BLANK_CYCLES(BL), .OVP_CYCLES(5)) dut_latch (
        .clock(clock), .rst_b(rst_b), .enable(enable), .mode_fpwm(mode_fpwm),
        .hs_over_limit(limit_lat), .light_load(light_load), .vout_prebiased(vout_prebiased),
        .meas(meas), .gate(gate_lat), .light_load_skip_mode(), .full_duty_mode(),
        .soft_start_active(), .on_time_cycles(), .power_ok_flag_o(),
        .power_ok_flag_oe(oe_lat), .fault_latched(fault_lat));
    bsfc_stage_model stage_hic (.overload(overload), .gate(gate_hic), .hs_over_limit(limit_hic));
    bsfc_stage_model stage_lat (.overload(overload), .gate(gate_lat), .hs_over_limit(limit_lat));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: bit got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_val(input logic [6:0] got, input logic [6:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: on-time got %0h expected %0h", $time, got, exp);
        end
    endtask : check_val
    function automatic logic pick(input int sel);
        case (sel)
            0: return ss_hic;
            1: return oe_hic;
            2: return gate_hic.hs_on;
            default: return fault_lat;
        endcase
    endfunction : pick
    // wait for a signal, then judge the cycle count against a window
    task automatic wait_sig(input int sel, input logic val, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(sel) !== val && n <= hi) begin
            @(posedge clock);
            #1;
            n++;
        end
        comparisons++;
        if (n < lo || n > hi) begin
            failures++;
            $display("Error at %0t: wait %0h took %0h, window %0h", $time, sel, n, hi);
        end
    endtask : wait_sig
    task automatic set_meas(input int vin, input int vout, input int fb, input int tc);
        @(posedge clock);
        meas <= '{vin_mv: 13'(vin), vout_mv: 13'(vout), fb_mv: 12'(fb), temp_c: 9'(tc)};
        #1;
    endtask : set_meas
    task automatic start_up;
        @(posedge clock);
        enable <= 1'b1;
        wait_sig(0, 1'b1, LD, LD + 5);
        wait_sig(0, 1'b0, SS, SS + 3);
        wait_sig(1, 1'b0, PD + BL - 1, PD + BL + 1);
        $display("start-up done");
    endtask : start_up
    // watch a stretch of overload: limit cuts the high side, no restart may follow
    task automatic watch(input int n);
        logic seen;
        logic prev;
        seen = 1'b0;
        repeat (n) begin
            prev = limit_hic;
            @(posedge clock);
            #1;
            seen = seen | ss_hic;
            if (prev) begin
                check_bit(gate_hic.hs_on, 1'b0);
                check_bit(gate_hic.ls_on, 1'b1);
            end
        end
        check_bit(seen, 1'b0);
    endtask : watch
    function automatic logic exp_skip(logic fp, logic ll, int vin, int vout);
        return !fp && ll && (vout * 100 <= vin * bsfc_pkg::DUTY_MAX_PCT);
    endfunction : exp_skip
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int vin;
        int vout;
        logic fp;
        logic ll;
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        enable = 1'b0;
        mode_fpwm = 1'b0;
        light_load = 1'b0;
        vout_prebiased = 1'b0;
        overload = 1'b0;
        meas = '{vin_mv: 13'h1388, vout_mv: 13'h0708, fb_mv: 12'h1F4, temp_c: 9'h019};
        void'($urandom(32'hA58069CF));
        repeat (12) @(posedge clock);
        #1;
        check_bit(oe_hic, 1'b1);
        check_bit(pgo_hic, 1'b0);
        check_bit(gate_hic.hs_on, 1'b0);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_bit(gate_hic.discharge_on, 1'b0);
        start_up();
        // light-load and duty cases: corners first, then random
        for (int i = 0; i < 10; i++) begin
            fp = (i == 0) ? 1'b1 : (i < 3) ? 1'b0 : 1'($urandom_range(1, 0));
            ll = (i < 3) ? 1'b1 : 1'($urandom_range(1, 0));
            vin = (i < 3) ? 5000 : int'($urandom_range(5499, 3000));
            vout = (i == 2) ? 4700 : (i < 2) ? 900 : int'($urandom_range(vin - 300, 500));
            @(posedge clock);
            mode_fpwm <= fp;
            light_load <= ll;
            set_meas(vin, vout, 500, 25);
            repeat (3 * PER) @(posedge clock);
            #1;
            check_bit(skip_hic, exp_skip(fp, ll, vin, vout));
            check_val(ont_hic, 7'(vout * PER / vin));
        end
        set_meas(5000, 4950, 500, 25);
        repeat (3 * PER) @(posedge clock);
        #1;
        check_bit(full_hic, 1'b1);
        check_bit(gate_hic.hs_on, 1'b1);
        check_bit(gate_hic.ls_on, 1'b0);
        set_meas(5000, 1800, 500, 25);
        mode_fpwm <= 1'b1;
        light_load <= 1'b0;
        repeat (3 * PER) @(posedge clock);
        $display("mode tests done");
        // two broken overload runs shorter than the trip count
        for (int k = 0; k < 2; k++) begin
            overload <= 1'b1;
            watch(20 * PER);
            @(posedge clock);
            overload <= 1'b0;
            watch(3 * PER);
        end
        check_bit(fault_lat, 1'b0);
        $display("limit tests done");
        set_meas(5000, 1800, 560, 25);
        wait_sig(3, 1'b1, 5, 5 + BL + 5);
        wait_sig(1, 1'b1, BL - 7, BL - 2);
        check_bit(oe_lat, 1'b1);
        check_bit(gate_lat.hs_on | gate_lat.ls_on, 1'b0);
        set_meas(5000, 1800, 540, 25);
        repeat (3 * BL) @(posedge clock);
        #1;
        check_bit(oe_hic, 1'b1);
        set_meas(5000, 1800, 520, 25);
        wait_sig(1, 1'b0, BL, BL + 5);
        @(posedge clock);
        enable <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check_bit(gate_hic.hs_on | gate_hic.ls_on, 1'b0);
        check_bit(gate_hic.discharge_on, 1'b1);
        check_bit(oe_hic, 1'b1);
        check_bit(fault_lat, 1'b0);
        $display("window and disable done");
        start_up();
        overload <= 1'b1;
        wait_sig(3, 1'b1, 31 * PER, 33 * PER + 10);
        check_bit(gate_lat.hs_on | gate_lat.ls_on, 1'b0);
        wait_sig(0, 1'b1, HC, 2 * PER + HC + 20);
        @(posedge clock);
        overload <= 1'b0;
        wait_sig(0, 1'b0, 1, SS + 3);
        $display("protection done");
        set_meas(5000, 1800, 500, 151);
        wait_sig(2, 1'b0, 0, 5);
        set_meas(5000, 1800, 500, 140);
        repeat (3 * PER) @(posedge clock);
        #1;
        check_bit(gate_hic.hs_on, 1'b0);
        check_bit(oe_hic, 1'b1);
        set_meas(5000, 1800, 500, 125);
        wait_sig(2, 1'b1, 1, LD + SS + 3 * PER);
        set_meas(2000, 1800, 500, 25);
        wait_sig(2, 1'b0, 0, 5);
        set_meas(2100, 1800, 500, 25);
        repeat (3 * PER) @(posedge clock);
        #1;
        check_bit(gate_hic.hs_on, 1'b0);
        $display("shutdown tests done");
        report_and_stop();
    end
endmodule : bsfc_top_tb
`default_nettype wire
